// [hw/tszsc_consts.vh]
// Register indices, field positions, codes and reset values of the timeslot control block
`ifndef TSZSC_CONSTS_VH
`define TSZSC_CONSTS_VH

`define TSZSC_IDX_SIG_LINK   10'h010A
`define TSZSC_IDX_PART       10'h01FE
`define TSZSC_IDX_REV        10'h01FF
`define TSZSC_IDX_SLOT_FIRST 10'h0300
`define TSZSC_IDX_SLOT_LAST  10'h0317

`define TSZSC_LINK_MSB       7
`define TSZSC_LINK_LSB       6
`define TSZSC_ZS_MSB         5
`define TSZSC_ZS_LSB         4
`define TSZSC_DE_MSB         3
`define TSZSC_DE_LSB         2

`define TSZSC_LINK_C1        2'h0
`define TSZSC_LINK_C2        2'h1
`define TSZSC_LINK_DE        2'h2
`define TSZSC_LINK_C3        2'h3

`define TSZSC_ZS_NONE        2'h0
`define TSZSC_ZS_BIT7        2'h1
`define TSZSC_ZS_BIT8        2'h2
`define TSZSC_ZS_DDS         2'h3

`define TSZSC_OCTET_ZERO     8'h00
`define TSZSC_OCTET_BIT7     8'h02
`define TSZSC_OCTET_BIT8     8'h01
`define TSZSC_OCTET_DDS      8'h98

`define TSZSC_SLOT_RESET     8'h00
`define TSZSC_SIG_LINK_RESET 8'h00
`define TSZSC_HSIZE_WORD     3'h2
`define TSZSC_HTRANS_NONSEQ  2'h2

`endif

// [hw/tszsc_zero_supp.v]
// Zero code suppression of one outgoing timeslot octet
`timescale 1ns/1ps
`include "tszsc_consts.vh"

module tszsc_zero_supp (
    input  wire [1:0] mode_i,
    input  wire       sig_frame_i,
    input  wire [7:0] octet_i,
    output reg  [7:0] octet_o
);

    wire is_zero;

    assign is_zero = (octet_i == `TSZSC_OCTET_ZERO);

    // Bit 1 is the octet MSB, bit 8 the LSB
    always @* begin
        octet_o = octet_i;
        if (is_zero) begin
            case (mode_i)
                `TSZSC_ZS_NONE: octet_o = octet_i;
                `TSZSC_ZS_BIT7: octet_o = `TSZSC_OCTET_BIT7;
                `TSZSC_ZS_BIT8: begin
                    if (sig_frame_i) begin
                        octet_o = `TSZSC_OCTET_BIT7;
                    end else begin
                        octet_o = `TSZSC_OCTET_BIT8;
                    end
                end
                `TSZSC_ZS_DDS:  octet_o = `TSZSC_OCTET_DDS;
                default:        octet_o = octet_i;
            endcase
        end
    end

endmodule

// [hw/tszsc_ctrl.v]
// AHB-Lite register file and per-timeslot transmit control of the T1 outbound stream
`timescale 1ns/1ps
`include "tszsc_consts.vh"

// Operation
// - Twenty-four slot control registers, consecutive indices.
// - Link select 00/01/11 picks controller 1/2/3.
// - Link select 10 uses D/E source field.
// - Zero mode 00 sends octet untouched.
// - Zero mode 01 stuffs bit 7.
// - Mode 10: bit 8, or bit 7 signaling.
// - Mode 11 replaces an all-zero octet with 0x98.
// - Read-only part identifier, writes ignored.
// - Read-only revision identifier, value may change.
module tszsc_ctrl #(
    parameter       SLOTS     = 24,
    parameter       ADDR_W    = 12,
    parameter [7:0] PART_CODE = 8'hA7,
    parameter [7:0] REV_CODE  = 8'h5A
) (
    input  wire              clk_i,
    input  wire              rst_n_i,
    input  wire              hsel_i,
    input  wire [ADDR_W-1:0] haddr_i,
    input  wire [1:0]        htrans_i,
    input  wire              hwrite_i,
    input  wire [2:0]        hsize_i,
    input  wire [31:0]       hwdata_i,
    input  wire              hready_i,
    output wire              hreadyout_o,
    output wire              hresp_o,
    output reg  [31:0]       hrdata_o,
    input  wire              ts_valid_i,
    input  wire [4:0]        ts_slot_i,
    input  wire [7:0]        ts_octet_i,
    input  wire              ts_sig_frame_i,
    output reg               line_valid_o,
    output reg  [4:0]        line_slot_o,
    output reg  [7:0]        line_octet_o,
    output reg  [2:0]        line_link_ctrl_o,
    output reg               line_de_ext_o,
    output reg  [1:0]        line_de_src_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WR   = 3'b010;
    localparam [2:0] ST_RD   = 3'b100;

    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [9:0] dp_idx;
    reg        dp_ok;
    reg        rd_fill;
    reg        next_rd_fill;
    reg  [7:0] slot_ctrl [0:SLOTS-1];
    reg  [7:0] sig_link;
    reg  [7:0] rd_byte;
    reg        next_line_valid;
    reg  [4:0] next_line_slot;
    reg  [7:0] next_line_octet;
    reg  [2:0] next_line_link;
    reg        next_line_de;
    reg  [1:0] next_line_src;

    wire       addr_take;
    wire       word_ok;
    wire [7:0] cur_ctrl;
    wire       cur_hit;
    wire [1:0] cur_link;
    wire [1:0] cur_zs;
    wire [7:0] supp_octet;
    wire [3:0] route;
    wire       wr_slot;
    wire       wr_sig;

    integer    k;

    function slot_hit;
        input [9:0] idx;
        begin
            slot_hit = (idx >= `TSZSC_IDX_SLOT_FIRST) && (idx <= `TSZSC_IDX_SLOT_LAST);
        end
    endfunction

    function [4:0] slot_of;
        input [9:0] idx;
        reg   [9:0] diff;
        begin
            diff    = idx - `TSZSC_IDX_SLOT_FIRST;
            slot_of = diff[4:0];
        end
    endfunction

    // Route of a slot: bit 3 D/E source, bits 2:0 one transmit controller
    function [3:0] link_route;
        input       hit;
        input [1:0] link;
        begin
            link_route = 4'h0;
            if (hit) begin
                case (link)
                    `TSZSC_LINK_C1: link_route = 4'h1;
                    `TSZSC_LINK_C2: link_route = 4'h2;
                    `TSZSC_LINK_C3: link_route = 4'h4;
                    `TSZSC_LINK_DE: link_route = 4'h8;
                    default:        link_route = 4'h0;
                endcase
            end
        end
    endfunction

    // Address phase acceptance
    assign addr_take   = hsel_i && hready_i && (htrans_i == `TSZSC_HTRANS_NONSEQ);
    assign word_ok     = (hsize_i == `TSZSC_HSIZE_WORD) && (haddr_i[1:0] == 2'h0);
    assign hreadyout_o = !(state == ST_RD && rd_fill);
    assign hresp_o     = 1'b0;

    always @* begin
        next_state   = ST_IDLE;
        next_rd_fill = 1'b0;
        case (state)
            ST_IDLE, ST_WR: begin
                if (addr_take) begin
                    next_state   = hwrite_i ? ST_WR : ST_RD;
                    next_rd_fill = !hwrite_i;
                end
            end
            ST_RD: begin
                if (rd_fill) begin
                    next_state   = ST_RD;
                    next_rd_fill = 1'b0;
                end else if (addr_take) begin
                    next_state   = hwrite_i ? ST_WR : ST_RD;
                    next_rd_fill = !hwrite_i;
                end
            end
            default: begin
                next_state   = ST_IDLE;
                next_rd_fill = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state   <= ST_IDLE;
            rd_fill <= 1'b0;
            dp_idx  <= 10'h000;
            dp_ok   <= 1'b0;
        end else begin
            state   <= next_state;
            rd_fill <= next_rd_fill;
            if (hreadyout_o && addr_take) begin
                dp_idx <= haddr_i[11:2];
                dp_ok  <= word_ok;
            end
        end
    end

    // Write strobes of the data phase; identifiers have none
    assign wr_slot = (state == ST_WR) && dp_ok && slot_hit(dp_idx);
    assign wr_sig  = (state == ST_WR) && dp_ok && (dp_idx == `TSZSC_IDX_SIG_LINK);

    // Register writes in the data phase
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (k = 0; k < SLOTS; k = k + 1) begin
                slot_ctrl[k] <= `TSZSC_SLOT_RESET;
            end
            sig_link <= `TSZSC_SIG_LINK_RESET;
        end else begin
            if (wr_slot) begin
                slot_ctrl[slot_of(dp_idx)] <= hwdata_i[7:0];
            end
            if (wr_sig) begin
                sig_link <= hwdata_i[7:0];
            end
        end
    end

    // Read decode; identifiers ignore writes
    always @* begin
        rd_byte = 8'h00;
        if (dp_ok) begin
            if (slot_hit(dp_idx)) begin
                rd_byte = slot_ctrl[slot_of(dp_idx)];
            end else if (dp_idx == `TSZSC_IDX_SIG_LINK) begin
                rd_byte = sig_link;
            end else if (dp_idx == `TSZSC_IDX_PART) begin
                rd_byte = PART_CODE;
            end else if (dp_idx == `TSZSC_IDX_REV) begin
                rd_byte = REV_CODE;
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (state == ST_RD && rd_fill) begin
            hrdata_o <= {24'h00_0000, rd_byte};
        end
    end

    // Timeslot octet path
    assign cur_hit  = ({27'h000_0000, ts_slot_i} < SLOTS);
    assign cur_ctrl = cur_hit ? slot_ctrl[ts_slot_i] : `TSZSC_SLOT_RESET;
    assign cur_link = cur_ctrl[`TSZSC_LINK_MSB:`TSZSC_LINK_LSB];
    assign cur_zs   = cur_hit ? cur_ctrl[`TSZSC_ZS_MSB:`TSZSC_ZS_LSB] : `TSZSC_ZS_NONE;

    tszsc_zero_supp u_zero_supp (
        .mode_i      (cur_zs),
        .sig_frame_i (ts_sig_frame_i),
        .octet_i     (ts_octet_i),
        .octet_o     (supp_octet)
    );

    assign route = link_route(cur_hit, cur_link);

    // Next values of the line outputs; all but line_valid_o hold while no octet arrives
    always @* begin
        next_line_valid = ts_valid_i;
        next_line_slot  = line_slot_o;
        next_line_octet = line_octet_o;
        next_line_link  = line_link_ctrl_o;
        next_line_de    = line_de_ext_o;
        next_line_src   = line_de_src_o;
        if (ts_valid_i) begin
            next_line_slot  = ts_slot_i;
            next_line_octet = supp_octet;
            next_line_link  = route[2:0];
            next_line_de    = route[3];
            if (route[3]) begin
                next_line_src = sig_link[`TSZSC_DE_MSB:`TSZSC_DE_LSB];
            end else begin
                next_line_src = 2'h0;
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            line_valid_o     <= 1'b0;
            line_slot_o      <= 5'h00;
            line_octet_o     <= 8'h00;
            line_link_ctrl_o <= 3'h0;
            line_de_ext_o    <= 1'b0;
            line_de_src_o    <= 2'h0;
        end else begin
            line_valid_o     <= next_line_valid;
            line_slot_o      <= next_line_slot;
            line_octet_o     <= next_line_octet;
            line_link_ctrl_o <= next_line_link;
            line_de_ext_o    <= next_line_de;
            line_de_src_o    <= next_line_src;
        end
    end

endmodule

// [dv/tszsc_line_model.sv]
// Outbound line model: counts each octet sent toward the line and keeps the last one
`timescale 1ns/1ps
module tszsc_line_model (
    input  wire        clk_i,
    input  wire        valid_i,
    input  wire [7:0]  octet_i,
    output reg  [7:0]  last_o,
    output reg  [15:0] count_o
);
initial last_o = 8'h00;
initial count_o = 16'h0000;
always @(posedge clk_i) begin
    if (valid_i === 1'b1) begin
        last_o <= octet_i;
        count_o <= count_o + 16'h0001;
    end
end
endmodule

// [dv/tszsc_ctrl_asserts.sv]
// Port assertions of the timeslot control block
`timescale 1ns/1ps
module tszsc_ctrl_asserts (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        hsel_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire        hready_i,
    input wire        hreadyout_o,
    input wire [31:0] hrdata_o,
    input wire        ts_valid_i,
    input wire [4:0]  ts_slot_i,
    input wire [7:0]  ts_octet_i,
    input wire        ts_sig_frame_i,
    input wire        line_valid_o,
    input wire [7:0]  line_octet_o,
    input wire [2:0]  line_link_ctrl_o,
    input wire        line_de_ext_o,
    input wire [1:0]  line_de_src_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
wire tk = hsel_i && hready_i && htrans_i == 2'h2;
wire zin = ts_valid_i && ts_octet_i == 8'h00 && ts_slot_i < 5'h18;
property p_rd; tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
a_rd: assert property (p_rd) else $error("read wait state wrong");
property p_wr; tk && hwrite_i |=> hreadyout_o; endproperty
a_wr: assert property (p_wr) else $error("write stalled");
property p_hi; hrdata_o[31:8] == 24'h00_0000; endproperty
a_hi: assert property (p_hi) else $error("upper read bits set");
property p_val; ts_valid_i |=> line_valid_o; endproperty
a_val: assert property (p_val) else $error("octet lost");
property p_one; !ts_valid_i |=> !line_valid_o; endproperty
a_one: assert property (p_one) else $error("spurious octet");
property p_nz; ts_valid_i && ts_octet_i != 8'h00 |=> line_octet_o == $past(ts_octet_i); endproperty
a_nz: assert property (p_nz) else $error("nonzero octet changed");
property p_zs; zin |=> line_octet_o inside {8'h00, 8'h01, 8'h02, 8'h98}; endproperty
a_zs: assert property (p_zs) else $error("bad suppression code");
property p_sig; zin && ts_sig_frame_i |=> line_octet_o != 8'h01; endproperty
a_sig: assert property (p_sig) else $error("bit 8 in signaling frame");
property p_lnk; ts_valid_i && ts_slot_i < 5'h18 |=> $onehot({line_de_ext_o, line_link_ctrl_o}); endproperty
a_lnk: assert property (p_lnk) else $error("routing not one-hot");
property p_src; line_valid_o && !line_de_ext_o |-> line_de_src_o == 2'h0; endproperty
a_src: assert property (p_src) else $error("source without D/E");
c_rd: cover property (tk && !hwrite_i);
c_dds: cover property (zin ##1 line_octet_o == 8'h98);
c_de: cover property (line_valid_o && line_de_ext_o);
endmodule
bind tszsc_ctrl tszsc_ctrl_asserts u_chk (.clk_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i,
    .hready_i, .hreadyout_o, .hrdata_o, .ts_valid_i, .ts_slot_i, .ts_octet_i, .ts_sig_frame_i,
    .line_valid_o, .line_octet_o, .line_link_ctrl_o, .line_de_ext_o, .line_de_src_o);

// [dv/tx_timeslot_zero_suppress_ctrl_tb.sv]
// Self-checking bench of the timeslot control block
`timescale 1ns/1ps
`include "tszsc_consts.vh"
module tx_timeslot_zero_suppress_ctrl_tb;
localparam [7:0] PART = 8'h3C; // Arbitrary part code
localparam [7:0] REV  = 8'h6B; // Arbitrary revision code
reg         clk_i = 0;
reg         rst_n_i = 0;
reg         hsel_i = 0;
reg  [11:0] haddr_i = 0;
reg  [1:0]  htrans_i = 0;
reg         hwrite_i = 0;
reg  [31:0] hwdata_i = 0;
reg         ts_valid_i = 0;
reg  [4:0]  ts_slot_i = 0;
reg  [7:0]  ts_octet_i = 0;
reg         ts_sig_frame_i = 0;
wire        hready;
wire        hresp;
wire [4:0]  line_slot;
wire        line_valid_o;
wire        line_de_ext_o;
wire [31:0] hrdata_o;
wire [7:0]  line_octet_o;
wire [2:0]  line_link_ctrl_o;
wire [1:0]  line_de_src_o;
wire [15:0] cnt;
integer     n_mismatch = 0;
integer     n_tests = 0;
integer     i;
integer     j;
reg  [31:0] rd;
reg  [7:0]  eo;
reg  [1:0]  l;
reg  [1:0]  m;
tszsc_ctrl #(.PART_CODE(PART), .REV_CODE(REV)) dut (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(`TSZSC_HSIZE_WORD), .hwdata_i, .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o, .ts_valid_i, .ts_slot_i, .ts_octet_i,
    .ts_sig_frame_i, .line_valid_o, .line_slot_o(line_slot), .line_octet_o, .line_link_ctrl_o,
    .line_de_ext_o, .line_de_src_o);
tszsc_line_model u_line (.clk_i(clk_i), .valid_i(line_valid_o), .octet_i(line_octet_o),
    .last_o(), .count_o(cnt));
initial begin
    forever #4 clk_i = ~clk_i;
end
task print_verdict;
    begin
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task bus(input w, input [11:0] a, input [31:0] d);
    begin
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= `TSZSC_HTRANS_NONSEQ;
        hwrite_i <= w;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rd = hrdata_o;
    end
endtask
task send(input [4:0] s, input [7:0] o, input sg);
    begin
        @(posedge clk_i);
        ts_valid_i <= 1'b1;
        ts_slot_i <= s;
        ts_octet_i <= o;
        ts_sig_frame_i <= sg;
        @(posedge clk_i);
        ts_valid_i <= 1'b0;
        #1;
    end
endtask
initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
end
initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, 12'hC5C, 0); chk(rd, 32'h0000_0000);
    bus(1, 12'h7F8, 32'h0000_00FF);
    bus(1, 12'h7FC, 32'h0000_00FF);
    bus(1, 12'hC60, 32'h0000_00FF);
    bus(1, 12'hC5C, 32'h0000_00E7);
    bus(0, 12'h7F8, 0); chk(rd, {24'h00_0000, PART});
    bus(0, 12'h7FC, 0); chk(rd, {24'h00_0000, REV});
    bus(0, 12'hC60, 0); chk(rd, 32'h0000_0000);
    bus(0, 12'hC5C, 0); chk(rd, 32'h0000_00E7);
    bus(1, 12'h428, 32'h0000_000C);
    for (i = 0; i < 16; i = i + 1) begin
        bus(1, 12'hC00 + {i[9:0], 2'b00}, {24'h00_0000, i[3:0], 4'h3});
    end
    for (i = 0; i < 16; i = i + 1) begin
        for (j = 0; j < 3; j = j + 1) begin
            l = i[3:2];
            m = i[1:0];
            eo = j == 2 ? 8'h5C : m == 2'h1 ? 8'h02 : m == 2'h3 ? 8'h98 :
                 m == 2'h2 ? (j == 1 ? 8'h02 : 8'h01) : 8'h00;
            send(i[4:0], j == 2 ? 8'h5C : 8'h00, j == 1);
            chk({hresp, line_slot, line_valid_o, line_octet_o, line_link_ctrl_o,
                 line_de_ext_o, line_de_src_o},
                {1'b0, i[4:0], 1'b1, eo, l == 2'h3, l == 2'h1, l == 2'h0, l == 2'h2,
                 l == 2'h2 ? 2'h3 : 2'h0});
        end
    end
    send(5'h17, 8'h00, 1'b0);
    chk({line_slot, line_valid_o, line_octet_o, line_link_ctrl_o, line_de_ext_o},
        {5'h17, 1'b1, 8'h01, 3'h4, 1'b0});
    send(5'h18, 8'h00, 1'b0);
    chk({line_slot, line_octet_o, line_link_ctrl_o, line_de_ext_o},
        {5'h18, 8'h00, 3'h0, 1'b0});
    @(posedge clk_i);
    #1;
    chk(cnt, 16'h0032);
    print_verdict;
end
endmodule
